// File: common/link_assign_pkg.sv
// Constants and types of the link-channel assignment field decoder
package link_assign_pkg;
  // Message octet positions
  localparam logic [3:0] OCT_MSG_FIRST = 4'h1;
  localparam logic [3:0] OCT_ENTRY0_FIRST = 4'h2;
  localparam logic [3:0] OCT_ENTRY1_FIRST = 4'h7;
  localparam logic [3:0] OCT_MSG_LAST = 4'hb;
  localparam logic [3:0] OCT_IDX_MAX = 4'hf;
  // Field positions inside one entry
  localparam logic [3:0] POS_UNIT = 4'h1;
  localparam logic [3:0] POS_SHIFT = 4'h2;
  localparam logic [3:0] POS_POWER = 4'h3;
  localparam logic [3:0] POS_PATTERN = 4'h4;
  localparam int UNIT_MSB = 6;
  localparam int POWER_MSB = 5;
  localparam int PAT_LSB = 4;
  localparam int UL_MIMO_LSB = 2;
  localparam int DL_MIMO_LSB = 0;
  // Timing step in picoseconds, magnitude of -4*30/(512+64) us
  localparam longint STEP_NUM_PS = 4 * 30 * 1000000;
  localparam longint STEP_DEN = 512 + 64;
  localparam logic [26:0] STEP_PS = 27'(STEP_NUM_PS / STEP_DEN);
  localparam logic [7:0] POWER_STEP_DB = 8'h03;
  // Pattern codes
  localparam logic [3:0] PAT_OFDMA_LAST = 4'h5;
  localparam logic [3:0] PAT_SC_FIRST = 4'h6;
  localparam logic [3:0] PAT_SC_LAST = 4'hb;
  localparam logic [3:0] PAT_RSVD_A = 4'hc;
  localparam logic [3:0] PAT_RSVD_B = 4'hd;
  localparam logic [3:0] PAT_NO_SUBSLOT = 4'he;
  localparam logic [3:0] PAT_NO_SECOND = 4'hf;
  // Register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MASK = 12'h008;
  localparam logic [11:0] REG_LAST = 12'h00c;
  localparam logic [11:0] REG_ADJUST = 12'h010;
  localparam logic [11:0] REG_COUNT = 12'h014;
  // Bit positions and reset values
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_REQ = 1;
  localparam int ST_DECODED = 0;
  localparam int ST_ERROR = 1;
  localparam int ST_DISCARD = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  typedef enum logic [1:0] {MIMO_SISO = 2'h0, MIMO_STBC2 = 2'h1, MIMO_STBC4 = 2'h2, MIMO_RSVD = 2'h3} mimo_t;
  typedef enum logic [2:0] {ST_WAIT = 3'b001, ST_ENTRY = 3'b010, ST_DONE = 3'b100} dec_state_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] octet;
  } msg_in_t;

  typedef struct packed {
    logic valid;
    logic entry;
    logic error;
    logic [7:0] resource_unit;
    logic [7:0] shift_steps;
    logic signed [26:0] timing_adjust_ps;
    logic signed [5:0] power_steps;
    logic signed [7:0] power_db;
    logic sc_variant;
    logic [2:0] core_seq;
    logic no_subslot;
    mimo_t ul_mimo;
    mimo_t dl_mimo;
  } assign_out_t;
endpackage : link_assign_pkg

// File: rtl/link_channel_assign_field_decoder.sv
// Link-channel assignment field decoder with APB registers
`timescale 1ns/100ps
module link_channel_assign_field_decoder import link_assign_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Message octet stream
  input wire msg_in_t msg,
  // Decoded entry
  output assign_out_t entry_out,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    dec_state_t st;
    logic [3:0] idx;
    logic [6:0] unit_code;
    logic [7:0] shift;
    logic [5:0] power;
    logic [1:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] entry_count;
    logic [7:0] last_pattern;
    assign_out_t out;
  } state_t;

  if (ADDR_W < 12) begin : g_check
    $error("ADDR_W must cover the register offsets");
  end

  state_t s;
  state_t next_s;

  // Comb helpers visible to checks
  logic take;
  logic [3:0] pos_idx;
  logic in_entry1;
  logic [3:0] epos;
  logic pat_take;
  logic [3:0] pat;
  logic pat_err;
  logic drop_second;
  logic [11:0] addr;
  logic setup;
  logic done;

  always_comb begin
    next_s = s;
    next_s.out.valid = 1'b0;
    addr = paddr[11:0];
    setup = psel && !penable;
    done = psel && penable && s.pready;
    take = msg.valid && s.ctrl[CTRL_ENABLE] && (msg.first || s.st == ST_ENTRY);
    pos_idx = msg.first ? OCT_MSG_FIRST : ((s.idx == OCT_IDX_MAX) ? OCT_IDX_MAX : s.idx + 4'h1);
    in_entry1 = pos_idx >= OCT_ENTRY1_FIRST;
    epos = in_entry1 ? pos_idx - OCT_ENTRY1_FIRST : pos_idx - OCT_ENTRY0_FIRST;
    pat_take = take && pos_idx >= OCT_ENTRY0_FIRST && pos_idx <= OCT_MSG_LAST && epos == POS_PATTERN;
    pat = msg.octet[PAT_LSB +: 4];
    drop_second = in_entry1 && pat == PAT_NO_SECOND;
    pat_err = pat == PAT_RSVD_A || pat == PAT_RSVD_B
      || (!in_entry1 && pat == PAT_NO_SECOND)
      || mimo_t'(msg.octet[UL_MIMO_LSB +: 2]) == MIMO_RSVD
      || mimo_t'(msg.octet[DL_MIMO_LSB +: 2]) == MIMO_RSVD;

    // Octet stream
    if (take) begin
      next_s.idx = pos_idx;
      next_s.st = (pos_idx >= OCT_MSG_LAST) ? ST_DONE : ST_ENTRY;
      if (pos_idx >= OCT_ENTRY0_FIRST && pos_idx <= OCT_MSG_LAST) begin
        case (epos)
          POS_UNIT: begin
            next_s.unit_code = msg.octet[UNIT_MSB:0];
          end
          POS_SHIFT: begin
            next_s.shift = msg.octet;
          end
          POS_POWER: begin
            next_s.power = msg.octet[POWER_MSB:0];
          end
          default: begin
          end
        endcase
      end
    end else if (msg.valid && msg.first) begin
      next_s.st = ST_WAIT;
    end

    // Register access
    next_s.pready = setup;
    if (setup) begin
      next_s.pslverr = 1'b0;
      case (addr)
        REG_CTRL: next_s.prdata = {30'h0, s.ctrl};
        REG_STATUS: next_s.prdata = {29'h0, s.status};
        REG_MASK: next_s.prdata = {29'h0, s.mask};
        REG_LAST: next_s.prdata = {s.last_pattern, s.out.shift_steps, s.out.resource_unit, 2'h0, s.out.power_steps};
        REG_ADJUST: next_s.prdata = {{5{s.out.timing_adjust_ps[26]}}, s.out.timing_adjust_ps};
        REG_COUNT: next_s.prdata = {16'h0, s.entry_count};
        default: begin
          next_s.prdata = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (done && pwrite && !s.pslverr) begin
      if (addr == REG_CTRL) begin
        next_s.ctrl = pwdata[1:0];
      end
      if (addr == REG_MASK) begin
        next_s.mask = pwdata[2:0];
      end
    end
    // Read clears only the bits returned
    if (done && !pwrite && addr == REG_STATUS) begin
      next_s.status = s.status & ~s.prdata[2:0];
    end

    // Entry decode, events set after the clear
    if (pat_take) begin
      if (in_entry1) begin
        next_s.st = ST_DONE;
      end
      if (!drop_second) begin
        if (s.ctrl[CTRL_REQ]) begin
          next_s.out.valid = 1'b1;
          next_s.out.entry = in_entry1;
          next_s.out.error = pat_err;
          next_s.out.resource_unit = {1'b0, s.unit_code} + 8'h01;
          next_s.out.shift_steps = s.shift;
          next_s.out.timing_adjust_ps = -27'(27'(s.shift) * STEP_PS);
          next_s.out.power_steps = s.power;
          next_s.out.power_db = 8'({{2{s.power[5]}}, s.power} * POWER_STEP_DB);
          next_s.out.no_subslot = pat == PAT_NO_SUBSLOT;
          next_s.out.ul_mimo = mimo_t'(msg.octet[UL_MIMO_LSB +: 2]);
          next_s.out.dl_mimo = mimo_t'(msg.octet[DL_MIMO_LSB +: 2]);
          if (pat <= PAT_OFDMA_LAST) begin
            next_s.out.sc_variant = 1'b0;
            next_s.out.core_seq = 3'(pat + 4'h1);
          end else if (pat <= PAT_SC_LAST) begin
            next_s.out.sc_variant = 1'b1;
            next_s.out.core_seq = 3'(pat - PAT_SC_FIRST + 4'h1);
          end else begin
            next_s.out.sc_variant = 1'b0;
            next_s.out.core_seq = 3'h0;
          end
          next_s.last_pattern = msg.octet;
          next_s.entry_count = s.entry_count + 16'h0001;
          next_s.status[ST_DECODED] = 1'b1;
          if (pat_err) begin
            next_s.status[ST_ERROR] = 1'b1;
          end
        end else begin
          next_s.status[ST_DISCARD] = 1'b1;
        end
      end
    end
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= ST_WAIT;
      s.ctrl <= CTRL_RESET;
      s.mask <= MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign entry_out = s.out;
  assign irq = s.irq;

  chk_unit_plus_one: assert property (@(posedge pclk) disable iff (!presetn)
    s.out.valid |-> s.out.resource_unit == {1'b0, $past(s.unit_code)} + 8'h01)
    else $error("resource unit not code plus one");

  chk_shift_scaled: assert property (@(posedge pclk) disable iff (!presetn)
    s.out.valid |-> s.out.timing_adjust_ps == -27'(27'(s.out.shift_steps) * STEP_PS)
      && s.out.shift_steps == $past(s.shift))
    else $error("timing adjust not scaled from shift");

  chk_power_steps: assert property (@(posedge pclk) disable iff (!presetn)
    s.out.valid |-> s.out.power_db == 8'({{2{s.out.power_steps[5]}}, s.out.power_steps} * POWER_STEP_DB))
    else $error("power dB not three per step");

  chk_pattern_map: assert property (@(posedge pclk) disable iff (!presetn)
    pat_take && !drop_second && s.ctrl[CTRL_REQ] && pat <= PAT_SC_LAST
      |=> s.out.core_seq >= 3'h1 && s.out.core_seq <= 3'h6 && s.out.sc_variant == ($past(pat) >= PAT_SC_FIRST))
    else $error("core sequence mapping wrong");

  chk_reserved_flag: assert property (@(posedge pclk) disable iff (!presetn)
    pat_take && s.ctrl[CTRL_REQ] && (pat == PAT_RSVD_A || pat == PAT_RSVD_B) |=> s.out.valid && s.out.error)
    else $error("reserved pattern not flagged");

  chk_second_absent: assert property (@(posedge pclk) disable iff (!presetn)
    pat_take && in_entry1 && pat == PAT_NO_SECOND |=> !s.out.valid ##1 !s.out.valid)
    else $error("absent second entry was presented");

  chk_first_absent: assert property (@(posedge pclk) disable iff (!presetn)
    pat_take && !in_entry1 && pat == PAT_NO_SECOND && s.ctrl[CTRL_REQ] |=> s.out.error && !s.out.entry)
    else $error("absent code in first entry not an error");

  chk_mimo_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    s.out.valid && (s.out.ul_mimo == MIMO_RSVD || s.out.dl_mimo == MIMO_RSVD) |-> s.out.error)
    else $error("reserved MIMO code not flagged");

  chk_no_request: assert property (@(posedge pclk) disable iff (!presetn)
    pat_take && !drop_second && !s.ctrl[CTRL_REQ] |=> !s.out.valid && s.status[ST_DISCARD])
    else $error("entry applied without outstanding request");

  chk_valid_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s.out.valid |=> !s.out.valid || $past(pat_take))
    else $error("valid longer than one cycle");

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> s.irq == |(s.status & s.mask))
    else $error("interrupt does not follow masked status");

endmodule : link_channel_assign_field_decoder

// File: bench/link_assign_sender.sv
// Base station model sending assignment messages octet by octet
`timescale 1ns/100ps
module link_assign_sender import link_assign_pkg::*; (
  // Clock
  input wire logic pclk,
  // Octet stream
  output msg_in_t msg
);
  initial msg = '0;

  // Octet 1 first, then both entries in their fixed places; gaps when slow
  task automatic send(input logic [10:0][7:0] m, input logic slow);
    for (int i = 0; i < 11; i++) begin
      if (slow) begin
        @(posedge pclk);
        msg <= '{1'b0, 1'b0, ~msg.octet};
      end
      @(posedge pclk);
      msg <= '{1'b1, i == 0, m[i]};
    end
    @(posedge pclk);
    msg <= '{1'b0, 1'b0, ~m[10]};
  endtask : send
endmodule : link_assign_sender

// File: bench/link_channel_assign_field_decoder_tb.sv
// Self-checking bench for the assignment field decoder
`timescale 1ns/100ps
module link_channel_assign_field_decoder_tb import link_assign_pkg::*; ();
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  msg_in_t msg;
  assign_out_t entry_out, x;
  assign_out_t exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int applied_cnt = 0;
  logic [7:0] last_t;
  int seed = 32'hf7d985c9;

  always #12.5 pclk = ~pclk;

  link_channel_assign_field_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg(msg), .entry_out(entry_out), .irq(irq));
  link_assign_sender sender_u (.pclk(pclk), .msg(msg));

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, want, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", pready, 1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb

  // Reference decode of one entry
  function automatic assign_out_t expect_entry(logic e, logic [7:0] u, logic [7:0] s, logic [7:0] p, logic [7:0] t);
    assign_out_t y;
    int c;
    int pw;
    y = '0;
    c = t[7:4];
    pw = $signed(p[5:0]);
    y.valid = 1'b1;
    y.entry = e;
    y.resource_unit = 8'(u[6:0]) + 8'h01;
    y.shift_steps = s;
    y.timing_adjust_ps = 27'(-(int'(s) * (120000000 / 576)));
    y.power_steps = p[5:0];
    y.power_db = 8'(pw * 3);
    y.sc_variant = c > 5 && c < 12;
    y.core_seq = 3'(c < 6 ? c + 1 : (c < 12 ? c - 5 : 0));
    y.no_subslot = c == 14;
    y.ul_mimo = mimo_t'(t[3:2]);
    y.dl_mimo = mimo_t'(t[1:0]);
    y.error = c == 12 || c == 13 || (c == 15 && !e) || t[3:2] == 2'h3 || t[1:0] == 2'h3;
    return y;
  endfunction : expect_entry

  // Builds a message with random fields, extremes when entry 0 uses code 0 or 15
  task automatic run_msg(input logic [7:0] t0, input logic [7:0] t1, input logic applied);
    logic [10:0][7:0] m;
    logic [7:0] t;
    m[0] = 8'h10;
    for (int e = 0; e < 2; e++) begin
      t = e ? t1 : t0;
      for (int k = 1; k < 5; k++) begin
        m[k + 5 * e] = t0[7:4] == 4'h0 ? 8'h00 : (t0[7:4] == 4'hf ? 8'hff : 8'($random(seed)));
      end
      m[5 + 5 * e] = t;
      if (applied && !(e == 1 && t[7:4] == 4'hf)) begin
        exp_q.push_back(expect_entry(1'(e), m[2 + 5 * e], m[3 + 5 * e], m[4 + 5 * e], t));
        applied_cnt++;
        last_t = t;
      end
    end
    sender_u.send(m, 1'($random(seed)));
    repeat (3) @(posedge pclk);
  endtask : run_msg

  always @(posedge pclk) begin
    if (entry_out.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected valid", 1, 0);
      end else begin
        x = exp_q.pop_front();
        check("entry", entry_out.entry, x.entry);
        check("error", entry_out.error, x.error);
        check("unit", entry_out.resource_unit, x.resource_unit);
        check("shift", entry_out.shift_steps, x.shift_steps);
        check("adjust", 32'(entry_out.timing_adjust_ps), 32'(x.timing_adjust_ps));
        check("power", {entry_out.power_steps, entry_out.power_db}, {x.power_steps, x.power_db});
        check("core", entry_out.core_seq, x.core_seq);
        if (x.core_seq != 3'h0) check("variant", entry_out.sc_variant, x.sc_variant);
        check("no subslot", entry_out.no_subslot, x.no_subslot);
        check("mimo", {entry_out.ul_mimo, entry_out.dl_mimo}, {x.ul_mimo, x.dl_mimo});
      end
    end
  end

  task automatic results();
    $display("TB: %0d comparisons, %0d errors", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    #750000;
    error_cnt++;
    results();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("irq idle", irq, 0);
    check("outputs idle", |entry_out, 0);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl reset", rd, 0);
    check("no slave error", err, 0);
    apb(1'b0, REG_MASK, 32'h0);
    check("mask reset", rd, 0);
    apb(1'b0, 12'hffc, 32'h0);
    check("unmapped", err, 1);
    check("unmapped data", rd, 0);
    apb(1'b1, REG_CTRL, 32'h3);
    for (int c = 0; c < 16; c++) begin
      run_msg({4'(c), 4'($random(seed))}, {c == 3 ? 4'hf : 4'((c * 5 + 1) % 15), 4'($random(seed))}, 1'b1);
    end
    apb(1'b0, REG_COUNT, 32'h0);
    check("count reg", rd, applied_cnt);
    apb(1'b0, REG_ADJUST, 32'h0);
    check("adjust reg", rd, 32'(x.timing_adjust_ps));
    apb(1'b0, REG_LAST, 32'h0);
    check("last reg", rd, {last_t, x.shift_steps, x.resource_unit, 2'h0, x.power_steps});
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", rd[2:0], 3'b011);
    check("irq masked", irq, 0);
    apb(1'b0, REG_STATUS, 32'h0);
    check("status cleared", rd[2:0], 3'b000);
    apb(1'b1, REG_MASK, 32'h7);
    apb(1'b1, REG_CTRL, 32'h1);
    run_msg(8'h00, 8'h15, 1'b0);
    check("irq raised", irq, 1);
    apb(1'b0, REG_STATUS, 32'h0);
    check("discard", rd[2:0], 3'b100);
    repeat (2) @(posedge pclk);
    check("irq cleared", irq, 0);
    check("pending", exp_q.size(), 0);
    results();
  end
endmodule : link_channel_assign_field_decoder_tb
